// ===== logic/block_link_controller.v
// Purpose: link controller for a half-duplex checksummed block protocol
// Assumes: AXI4-Lite register access, one clock, synchronous reset
// Notes:   text bytes live in a flip-flop buffer reached through the data port
// Contract
// - selection: code, destination, source, then ENQ
// - header: SOH, format, numbers, function, size, checksum
// - size byte is data count minus one
// - header bytes sum to zero modulo 256
// - text: STX, data, ETX, zero-sum checksum
// - at most 256 data bytes per text
// - characters go out least significant bit first
// - ACK to selection starts header transmission
// - NAK or no answer to selection ends link
// - selection retried once on NAK, thrice otherwise
// - header ACK moves master on to text
// - NAK resends block until limit, then EOT
// - wait-acknowledge: pause, then ask status by ENQ
// - silence or bad reply prompts ENQ, limited
// - at most three ENQs, mode-spaced intervals
// - text ACK or later error sends EOT
// - timers: 1/3 s reply, 32/96 s block
// - slave numbers windowed per timing mode
// - transmit ends with status code, error flag
// - receive reports header or no header, B2 error
// - role zero is master, otherwise slave
// - SOH is 01h, STX is 02h
// - EOT is 04h, hands sending to slave
// - ENQ is 05h
// - line runs at 38.4 kbit/s
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "link_regs.vh"
module block_link_controller #(
  parameter MS_CYCLES  = `TICK_MS * `CLK_KHZ,
  parameter BIT_CYCLES = `CLK_HZ / `LINE_BPS,
  parameter DEPTH      = 256
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi write
  input  wire [11:0] awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // axi read
  input  wire [11:0] araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // line
  input  wire        serial_rx,
  output wire        serial_tx,
  input  wire        line_driver_on
);
  localparam S_IDLE = 3'd0, S_SEND = 3'd1, S_WAIT = 3'd2, S_PAUSE = 3'd3, S_RX = 3'd4;
  localparam P_SEL = 3'd0, P_HDR = 3'd1, P_TXT = 3'd2, P_ENQ = 3'd3;
  localparam P_EOT = 3'd4, P_ACK = 3'd5, P_NAK = 3'd6;
  localparam K_IDLE = 3'd0, K_SEL = 3'd1, K_HDR = 3'd2, K_TXT = 3'd3;
  // ==========================================
  // registers
  reg [7:0]  fmt, dst, src, function_code, text_size, rpl, snds, ctmo, btmo, rtmo, role, eidl, rxn, rxe;
  reg [15:0] ptr;
  reg [7:0]  buffer [0:DEPTH-1];
  reg        mode, rx_after, busy, err;
  reg [7:0]  stat, rxcode;
  reg [2:0]  st, st_q, ph, blk, kind, pnext;
  reg [8:0]  idx;
  reg [7:0]  sum;
  reg [7:0]  sends;
  reg [1:0]  enqs;
  reg        nak_once, dle, finish, hdr_seen, txt_ok, bad;
  reg [19:0] tmr;
  reg [15:0] pre;
  reg        aw_h, w_h;
  reg [11:0] aw_a;
  reg [31:0] w_d;
  // ==========================================
  // line interface
  wire       tx_ready;
  wire       rx_valid;
  wire [7:0] rx_data;
  reg  [7:0] tx_byte;
  reg  [8:0] last;
  wire       tx_valid = (st == S_SEND);
  wire       tx_fire  = tx_valid && tx_ready;
  reg        d1, drv;
  byte_uart #(.BIT_CYCLES(BIT_CYCLES)) u_line (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tx_valid (tx_valid),
    .tx_data  (tx_byte),
    .tx_ready (tx_ready),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_pin   (serial_rx),
    .tx_pin   (serial_tx)
  );
  // ==========================================
  // outgoing byte for the current phase
  always @* begin
    tx_byte = `CH_EOT;
    last    = 9'd0;
    case (ph)
      P_SEL: begin
        last = 9'd3;
        case (idx[1:0])
          2'd0:    tx_byte = `CH_SEL;
          2'd1:    tx_byte = dst;
          2'd2:    tx_byte = src;
          default: tx_byte = `CH_ENQ;
        endcase
      end
      P_HDR: begin
        last = 9'd6;
        case (idx[2:0])
          3'd0:    tx_byte = `CH_SOH;
          3'd1:    tx_byte = (role == 8'h00) ? `FMT_MST : `FMT_SLV;
          3'd2:    tx_byte = dst;
          3'd3:    tx_byte = src;
          3'd4:    tx_byte = function_code;
          3'd5:    tx_byte = text_size;
          default: tx_byte = 8'h00 - sum;
        endcase
      end
      P_TXT: begin
        last = {1'b0, text_size} + 9'd3;
        if (idx == 9'd0)
          tx_byte = `CH_STX;
        else if (idx == last)
          tx_byte = 8'h00 - sum;
        else if (idx == last - 9'd1)
          tx_byte = `CH_ETX;
        else
          tx_byte = buffer[idx[7:0] - 8'h01];
      end
      P_ENQ:   tx_byte = `CH_ENQ;
      P_ACK:   tx_byte = `CH_ACK;
      P_NAK:   tx_byte = `CH_NAK;
      default: tx_byte = `CH_EOT;
    endcase
  end
  // ==========================================
  // supervision timer, cleared on every new wait
  reg  [19:0] limit;
  wire [19:0] mult = mode ? `MODE1_MULT : 20'd1;
  wire [19:0] rlim = {12'h000, rtmo} * `CHR_UNIT_MS * mult;
  always @* begin
    if (st == S_PAUSE && finish)
      limit = {12'h000, eidl};
    else if (st == S_RX && kind == K_IDLE)
      limit = {12'h000, btmo} * `BLK_UNIT_MS * mult;
    else if (st == S_RX)
      limit = {12'h000, ctmo} * `CHR_UNIT_MS * mult;
    else
      limit = rlim;
  end
  wire ms_tick = (pre == MS_CYCLES[15:0] - 16'h0001);
  wire tmo     = (tmr >= limit);
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre  <= 16'h0000;
      tmr  <= 20'h00000;
      st_q <= S_IDLE;
      d1   <= 1'b0;
      drv  <= 1'b0;
    end else begin
      d1   <= line_driver_on;
      drv  <= d1;
      st_q <= st;
      pre  <= ms_tick ? 16'h0000 : pre + 16'h0001;
      if (st != st_q || rx_valid || tx_fire)
        tmr <= 20'h00000;
      else if (ms_tick && !tmo)
        tmr <= tmr + 20'h00001;
    end
  end
  // ==========================================
  // axi slave
  assign awready = !aw_h && !bvalid;
  assign wready  = !w_h && !bvalid;
  assign arready = !rvalid;
  wire [11:0] wa   = awvalid && awready ? awaddr : aw_a;
  wire [31:0] wd   = wvalid && wready ? wdata : w_d;
  wire        wgo  = (aw_h || awvalid) && (w_h || wvalid) && !bvalid;
  wire [9:0]  widx = wa[11:2];
  wire        rgo  = arvalid && arready;
  wire [9:0]  ridx = araddr[11:2];
  reg  [31:0] rmux;
  reg         rhit;
  always @* begin
    rhit = 1'b1;
    case (ridx)
      `IDX_FMT:  rmux = {24'h0, fmt};
      `IDX_DST:  rmux = {24'h0, dst};
      `IDX_SRC:  rmux = {24'h0, src};
      `IDX_FNC:  rmux = {24'h0, function_code};
      `IDX_SIZ:  rmux = {24'h0, text_size};
      `IDX_RPL:  rmux = {24'h0, rpl};
      `IDX_SNDS: rmux = {24'h0, snds};
      `IDX_CTMO: rmux = {24'h0, ctmo};
      `IDX_BTMO: rmux = {24'h0, btmo};
      `IDX_RTMO: rmux = {24'h0, rtmo};
      `IDX_ROLE: rmux = {24'h0, role};
      `IDX_EIDL: rmux = {24'h0, eidl};
      `IDX_RXN:  rmux = {24'h0, rxn};
      `IDX_RXE:  rmux = {24'h0, rxe};
      `IDX_SPR:  rmux = 32'h0;
      `IDX_PTR:  rmux = {16'h0, ptr};
      `IDX_CTRL: rmux = {28'h0, mode, 1'b0, rx_after, 1'b0};
      `IDX_STAT: rmux = {8'h0, rxcode, stat, 6'h0, err, busy};
      `IDX_DATA: rmux = {24'h0, buffer[ptr[7:0]]};
      default: begin
        rmux = 32'h0;
        rhit = 1'b0;
      end
    endcase
  end
  // window check per timing mode
  wire dev_ok = mode ? (dst >= `DEV1_LO && dst <= `DEV1_HI)
                     : (dst >= `DEV0_LO && dst <= `DEV0_HI);
  wire [7:0] nsum = sum + rx_data;
  // ==========================================
  // register file and link sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      fmt <= 8'h00; dst <= 8'h00; src <= 8'h00; function_code <= 8'h00; text_size <= 8'h00;
      rpl <= 8'h00; snds <= `RST_SNDS; ctmo <= `RST_CTMO; btmo <= `RST_BTMO;
      rtmo <= `RST_RTMO; role <= 8'h00; eidl <= `RST_EIDL; rxn <= 8'h00;
      rxe <= 8'h00; ptr <= 16'h0000; mode <= 1'b0; rx_after <= 1'b0;
      busy <= 1'b0; err <= 1'b0; stat <= `ST_OK; rxcode <= `RX_HDR;
      st <= S_IDLE; ph <= P_SEL; blk <= P_SEL; kind <= K_IDLE; pnext <= P_ENQ;
      idx <= 9'd0; sum <= 8'h00; sends <= 8'h00; enqs <= 2'd0;
      nak_once <= 1'b0; dle <= 1'b0; finish <= 1'b0;
      hdr_seen <= 1'b0; txt_ok <= 1'b0; bad <= 1'b0;
      aw_h <= 1'b0; w_h <= 1'b0; aw_a <= 12'h000; w_d <= 32'h0;
      bvalid <= 1'b0; bresp <= 2'b00; rvalid <= 1'b0; rresp <= 2'b00;
      rdata <= 32'h0;
    end else begin
      // bus handshakes
      if (awvalid && awready) begin
        aw_h <= 1'b1;
        aw_a <= awaddr;
      end
      if (wvalid && wready) begin
        w_h <= 1'b1;
        w_d <= wdata;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (rgo) begin
        rvalid <= 1'b1;
        rdata  <= rmux;
        rresp  <= rhit ? 2'b00 : 2'b10;
        if (ridx == `IDX_DATA)
          ptr <= ptr + 16'h0001;
      end
      if (wgo) begin
        aw_h   <= 1'b0;
        w_h    <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= 2'b00;
        case (widx)
          `IDX_FMT:  fmt  <= wd[7:0];
          `IDX_DST:  dst  <= wd[7:0];
          `IDX_SRC:  src  <= wd[7:0];
          `IDX_FNC:  function_code  <= wd[7:0];
          `IDX_SIZ:  text_size  <= wd[7:0];
          `IDX_RPL:  rpl  <= wd[7:0];
          `IDX_SNDS: snds <= wd[7:0];
          `IDX_CTMO: ctmo <= wd[7:0];
          `IDX_BTMO: btmo <= wd[7:0];
          `IDX_RTMO: rtmo <= wd[7:0];
          `IDX_ROLE: role <= wd[7:0];
          `IDX_EIDL: eidl <= wd[7:0];
          `IDX_RXN:  rxn  <= wd[7:0];
          `IDX_RXE:  rxe  <= wd[7:0];
          `IDX_SPR:  ;
          `IDX_PTR:  ptr  <= wd[15:0];
          `IDX_DATA: begin
            buffer[ptr[7:0]] <= wd[7:0];
            ptr <= ptr + 16'h0001;
          end
          `IDX_CTRL: begin
            // start commands are ignored while a transfer runs, mode and rx_after are always written
            mode     <= wd[`CTL_MODE];
            rx_after <= wd[`CTL_RXA];
            if (!busy && wd[`CTL_TX]) begin
              busy <= 1'b1; err <= 1'b0; finish <= 1'b0; idx <= 9'd0;
              sum <= 8'h00; sends <= 8'h01; enqs <= 2'd0; nak_once <= 1'b0;
              if (!drv) begin
                busy <= 1'b0; err <= 1'b1; stat <= `ST_DRV;
              end else if (role == 8'h00 && !dev_ok) begin
                busy <= 1'b0; err <= 1'b1; stat <= `ST_NLK;
              end else begin
                st <= S_SEND;
                ph  <= (role == 8'h00) ? P_SEL : P_HDR;
                blk <= (role == 8'h00) ? P_SEL : P_HDR;
              end
            end else if (!busy && wd[`CTL_RX]) begin
              busy <= 1'b1; err <= 1'b0; st <= S_RX; kind <= K_IDLE;
              hdr_seen <= 1'b0; txt_ok <= 1'b0; finish <= 1'b0;
            end
          end
          default: bresp <= 2'b10;
        endcase
      end
      // link sequencer
      case (st)
        S_IDLE: ;
        S_SEND: if (tx_fire) begin
          sum <= sum + tx_byte;
          idx <= idx + 9'd1;
          if (idx == last) begin
            idx <= 9'd0;
            sum <= 8'h00;
            dle <= 1'b0;
            if (ph == P_ACK || ph == P_NAK) begin
              st <= S_RX;
              kind <= K_IDLE;
            end else if (ph == P_EOT) begin
              if (!finish && rx_after) begin
                st <= S_RX; kind <= K_IDLE; hdr_seen <= 1'b0; txt_ok <= 1'b0;
              end else begin
                st <= S_PAUSE;
                finish <= 1'b1;
              end
            end else
              st <= S_WAIT;
          end
        end
        S_WAIT: if (rx_valid) begin
          rpl <= rx_data;
          if (rx_data == `CH_DLE && !dle)
            dle <= 1'b1;
          else begin
            dle <= 1'b0;
            if (rx_data == `CH_ACK) begin
              enqs <= 2'd0;
              sends <= 8'h01;
              st <= S_SEND;
              if (blk == P_SEL) begin
                ph <= P_HDR; blk <= P_HDR;
              end else if (blk == P_HDR) begin
                ph <= P_TXT; blk <= P_TXT;
              end else begin
                ph <= P_EOT; stat <= `ST_OK;
              end
            end else if (rx_data == `CH_NAK && blk == P_SEL) begin
              st <= S_SEND;
              if (nak_once) begin
                ph <= P_EOT; finish <= 1'b1; err <= 1'b1; stat <= `ST_NLK;
              end else begin
                nak_once <= 1'b1; ph <= P_SEL;
              end
            end else if (rx_data == `CH_NAK) begin
              st <= S_SEND;
              if (sends >= snds) begin
                ph <= P_EOT; finish <= 1'b1; err <= 1'b1; stat <= `ST_COM;
              end else begin
                sends <= sends + 8'h01; ph <= blk;
              end
            end else if (dle && rx_data == `CH_WAK && blk != P_SEL) begin
              st <= S_PAUSE; pnext <= P_ENQ;
            end else if (enqs == `ENQ_TRIES) begin
              st <= S_SEND; ph <= P_EOT; finish <= 1'b1; err <= 1'b1;
              stat <= (blk == P_SEL) ? `ST_NLK : `ST_TMO;
            end else begin
              enqs <= enqs + 2'd1; st <= S_PAUSE;
              pnext <= (blk == P_SEL) ? P_SEL : P_ENQ;
            end
          end
        end else if (tmo) begin
          st <= S_SEND;
          if (enqs == `ENQ_TRIES) begin
            ph <= P_EOT; finish <= 1'b1; err <= 1'b1;
            stat <= (blk == P_SEL) ? `ST_NLK : `ST_TMO;
          end else begin
            enqs <= enqs + 2'd1;
            ph <= (blk == P_SEL) ? P_SEL : P_ENQ;
          end
        end
        S_PAUSE: if (tmo) begin
          if (finish) begin
            st <= S_IDLE; busy <= 1'b0; finish <= 1'b0;
          end else begin
            st <= S_SEND; ph <= pnext;
          end
        end
        S_RX: if (rx_valid) begin
          idx <= idx + 9'd1;
          sum <= nsum;
          case (kind)
            K_IDLE: begin
              idx <= 9'd0; sum <= rx_data; bad <= 1'b0;
              if (rx_data == `CH_SEL) kind <= K_SEL;
              else if (rx_data == `CH_SOH) kind <= K_HDR;
              else if (rx_data == `CH_STX) begin
                kind <= K_TXT; ptr <= 16'h0000; rxn <= 8'h00;
              end else if (rx_data == `CH_EOT) begin
                st <= S_IDLE; busy <= 1'b0; err <= !txt_ok;
                stat <= txt_ok ? `ST_OK : `ST_COM;
              end
            end
            K_SEL: if (idx == 9'd2) begin
              kind <= K_IDLE; st <= S_SEND;
              ph <= (rx_data == `CH_ENQ && !bad) ? P_ACK : P_NAK;
            end else if (idx == 9'd0 && rx_data != src)
              bad <= 1'b1;
            K_HDR: begin
              case (idx[2:0])
                3'd0: fmt <= rx_data;
                3'd1: dst <= rx_data;
                3'd2: src <= rx_data;
                3'd3: function_code <= rx_data;
                3'd4: text_size <= rx_data;
                default: ;
              endcase
              if (idx == 9'd5) begin
                kind <= K_IDLE; st <= S_SEND;
                hdr_seen <= (nsum == 8'h00);
                ph <= (nsum == 8'h00) ? P_ACK : P_NAK;
                if (nsum != 8'h00) rxe <= `ST_COM;
              end
            end
            K_TXT: begin
              if (idx <= {1'b0, text_size}) begin
                buffer[ptr[7:0]] <= rx_data;
                ptr <= ptr + 16'h0001;
                rxn <= rxn + 8'h01;
              end else if (idx == {1'b0, text_size} + 9'd1) begin
                if (rx_data != `CH_ETX) bad <= 1'b1;
              end else begin
                kind <= K_IDLE; st <= S_SEND;
                if (nsum == 8'h00 && !bad) begin
                  ph <= P_ACK; txt_ok <= 1'b1;
                  rxcode <= hdr_seen ? `RX_HDR : `RX_NOH;
                end else begin
                  ph <= P_NAK; rxe <= `ST_COM;
                end
              end
            end
            default: kind <= K_IDLE;
          endcase
        end else if (tmo) begin
          st <= S_IDLE; busy <= 1'b0; err <= 1'b1; stat <= `ST_TMO;
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule // block_link_controller

// ===== logic/link_regs.vh
// Purpose: constants for the checksummed block link controller
// Assumes: included by bare name from design files under logic/
// Notes:   register offsets are word indices, byte address is index times four
`ifndef LINK_REGS_VH
`define LINK_REGS_VH
// ==========================================
// register indices
`define IDX_FMT   10'h1c4
`define IDX_DST   10'h1c5
`define IDX_SRC   10'h1c6
`define IDX_FNC   10'h1c7
`define IDX_SIZ   10'h1c8
`define IDX_RPL   10'h1c9
`define IDX_SNDS  10'h1ca
`define IDX_CTMO  10'h1cb
`define IDX_BTMO  10'h1cc
`define IDX_RTMO  10'h1cd
`define IDX_ROLE  10'h1ce
`define IDX_EIDL  10'h1cf
`define IDX_RXN   10'h1d0
`define IDX_RXE   10'h1d1
`define IDX_SPR   10'h1d2
`define IDX_PTR   10'h1d3
`define IDX_CTRL  10'h1d5
`define IDX_STAT  10'h1d6
`define IDX_DATA  10'h1d7
// ==========================================
// control bits
`define CTL_TX    0
`define CTL_RXA   1
`define CTL_RX    2
`define CTL_MODE  3
// ==========================================
// reset values and ENQ retry limit
`define RST_SNDS  8'h03
`define RST_CTMO  8'h0a
`define RST_BTMO  8'h20
`define RST_RTMO  8'h0a
`define RST_EIDL  8'h01
`define ENQ_TRIES 2'h3
// ==========================================
// characters
`define CH_SEL 8'h31
`define CH_SOH 8'h01
`define CH_STX 8'h02
`define CH_ETX 8'h03
`define CH_EOT 8'h04
`define CH_ENQ 8'h05
`define CH_ACK 8'h06
`define CH_NAK 8'h15
`define CH_DLE 8'h10
`define CH_WAK 8'h3b
`define FMT_MST 8'h00
`define FMT_SLV 8'h01
// ==========================================
// status codes
`define ST_OK   8'h00
`define ST_TMO  8'hb0
`define ST_NLK  8'hb1
`define ST_COM  8'hb2
`define ST_DRV  8'hb3
`define RX_HDR  8'h00
`define RX_NOH  8'h01
// ==========================================
// device number windows
`define DEV0_LO 8'h30
`define DEV0_HI 8'h3f
`define DEV1_LO 8'h40
`define DEV1_HI 8'h5f
// ==========================================
// timing
`define CLK_KHZ    20000
`define CLK_HZ     20000000
`define LINE_BPS   38400
`define TICK_MS    1
`define CHR_UNIT_MS 20'd100
`define BLK_UNIT_MS 20'd1000
`define MODE1_MULT  20'd3
`endif

// ===== logic/byte_uart.v
// Purpose: 8n1 byte transmitter and receiver for the block link
// Assumes: rx pin is asynchronous, idle high
// Notes:   framing errors are dropped, not reported
`timescale 1ns/1ps
module byte_uart #(
  parameter BIT_CYCLES = 520
) (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // transmit side
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  output wire       tx_ready,
  // receive side
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  // pins
  input  wire       rx_pin,
  output reg        tx_pin
);
  // ==========================================
  // transmit, lsb first
  reg [15:0] tcnt;
  reg [3:0]  tbit;
  reg [8:0]  tsh;
  assign tx_ready = (tbit == 4'h0);
  always @(posedge aclk) begin
    if (!aresetn) begin
      tcnt   <= 16'h0000;
      tbit   <= 4'h0;
      tsh    <= 9'h1ff;
      tx_pin <= 1'b1;
    end else if (tbit == 4'h0) begin
      if (tx_valid) begin
        tsh    <= {tx_data, 1'b0};
        // one count more than the frame so the stop bit stands a full bit
        tbit   <= 4'hb;
        tcnt   <= 16'h0000;
      end
      tx_pin <= 1'b1;
    end else if (tcnt == 16'h0000) begin
      tx_pin <= tsh[0];
      tsh    <= {1'b1, tsh[8:1]};
      tcnt   <= BIT_CYCLES[15:0] - 16'h0001;
      tbit   <= tbit - 4'h1;
    end else begin
      tcnt <= tcnt - 16'h0001;
    end
  end
  // ==========================================
  // receive, two flops before use
  reg        s1;
  reg        s2;
  reg [15:0] rcnt;
  reg [3:0]  rbit;
  reg [7:0]  rsh;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1       <= 1'b1;
      s2       <= 1'b1;
      rcnt     <= 16'h0000;
      rbit     <= 4'h0;
      rsh      <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      s1       <= rx_pin;
      s2       <= s1;
      rx_valid <= 1'b0;
      if (rbit == 4'h0) begin
        if (!s2) begin
          rbit <= 4'ha;
          rcnt <= BIT_CYCLES[16:1];
        end
      end else if (rcnt == 16'h0000) begin
        rcnt <= BIT_CYCLES[15:0] - 16'h0001;
        rbit <= rbit - 4'h1;
        if (rbit == 4'ha && s2)
          rbit <= 4'h0;
        else if (rbit == 4'h1) begin
          rx_valid <= s2;
          rx_data  <= rsh;
        end else if (rbit != 4'ha)
          rsh <= {s2, rsh[7:1]};
      end else begin
        rcnt <= rcnt - 16'h0001;
      end
    end
  end
endmodule // byte_uart

// ===== dv/link_props.sv
// Purpose: bus and line checks at the controller ports
// Assumes: bound to block_link_controller, one clock
// Notes:   start bit check needs BIT_CYCLES above 8
`timescale 1ns/1ps
module link_props (
  // clock, reset and bus
  input wire        aclk,
  input wire        aresetn,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire [1:0]  rresp,
  input wire        rvalid,
  input wire        rready,
  // line
  input wire        serial_tx
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b; awvalid && awready && wvalid && wready |=> bvalid; endproperty
  a_b: assert property (p_b) else $error("write answer late");
  property p_bh; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
  property p_r; arvalid && arready |=> rvalid; endproperty
  a_r: assert property (p_r) else $error("read answer late");
  property p_rh; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rh: assert property (p_rh) else $error("read answer dropped");
  property p_arb; rvalid |-> !arready; endproperty
  a_arb: assert property (p_arb) else $error("read taken while busy");
  property p_awb; bvalid |-> !awready && !wready; endproperty
  a_awb: assert property (p_awb) else $error("write taken while busy");
  property p_err; rvalid && rresp == 2'b10 |-> rdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_st; $fell(serial_tx) |=> !serial_tx [*8]; endproperty
  a_st: assert property (p_st) else $error("start bit short");
endmodule // link_props
bind block_link_controller link_props chk (.*);

// ===== dv/link_partner.sv
// Purpose: remote slave station on the serial line
// Assumes: 8n1 at BIT_NS per bit, line idle high
// Notes:   naks sets how many header NAKs are given
`timescale 1ns/1ps
module link_partner #(
  parameter BIT_NS = 800
) (
  // line
  input  wire serial_tx,
  output reg  serial_rx
);
  reg [7:0] got [$];
  reg [7:0] b;
  reg [9:0] f;
  integer   naks = 0;
  integer   cnt = 0;
  integer   len = 0;
  integer   text_size = 0;
  integer   i;
  initial serial_rx = 1'b1;
  always begin
    @(negedge serial_tx);
    #(BIT_NS * 3 / 2);
    for (i = 0; i < 8; i = i + 1) begin
      b[i] = serial_tx;
      #BIT_NS;
    end
    got.push_back(b);
    if (cnt == 0)
      len = b == 8'h31 ? 4 : b == 8'h01 ? 7 : b == 8'h02 ? text_size + 4 : 1;
    if (len == 7 && cnt == 5)
      text_size = b;
    cnt = cnt + 1;
    if (cnt == len) begin
      cnt = 0;
      #(BIT_NS * 2);
      // only header frames are refused, so the resend path is hit once
      f = {1'b1, (naks > 0 && len == 7) ? 8'h15 : 8'h06, 1'b0};
      if (naks > 0 && len == 7)
        naks = naks - 1;
      for (i = 0; i < 10 && len > 1; i = i + 1) begin
        serial_rx = f[i];
        // listen again from the start of the stop bit, the controller answers from mid stop bit
        if (i < 9) #BIT_NS;
      end
    end
  end
endmodule // link_partner

// ===== dv/block_link_controller_bench.sv
// Purpose: register and link checks for the controller
// Assumes: short ms and bit counts
// Notes:   frame bytes are compared in order
`timescale 1ns/1ps
`include "link_regs.vh"
module block_link_controller_bench;
  reg         aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  reg         arvalid = 0, rready = 0, drv = 0, ok;
  reg  [11:0] awaddr = 0, araddr = 0;
  reg  [31:0] wdata = 0, rq;
  reg  [7:0]  s;
  reg  [1:0]  rs;
  reg  [7:0]  ex [$];
  wire        awready, wready, bvalid, arready, rvalid, serial_rx, serial_tx;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     fails = 0, tests_run = 0, k, n;
  block_link_controller #(.MS_CYCLES(20), .BIT_CYCLES(16)) uut (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .serial_rx(serial_rx),
    .serial_tx(serial_tx), .line_driver_on(drv));
  link_partner #(.BIT_NS(800)) p (.serial_tx(serial_tx), .serial_rx(serial_rx));
  initial forever #25 aclk = ~aclk;
  task final_report;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [9:0] i, input [31:0] d);
    begin
      awaddr <= {i, 2'b00};
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      ok = 0;
      for (k = 0; k < 99 && !ok; k = k + 1) begin
        @(posedge aclk);
        if (awready) awvalid <= 0;
        if (wready) wvalid <= 0;
        if (bvalid) begin
          bready <= 0;
          rs = bresp;
          ok = 1;
        end
      end
      if (!ok) begin
        fails = fails + 1;
        final_report;
      end
      @(posedge aclk);
    end
  endtask
  task rd(input [9:0] i);
    begin
      araddr <= {i, 2'b00};
      arvalid <= 1;
      rready <= 1;
      ok = 0;
      for (k = 0; k < 99 && !ok; k = k + 1) begin
        @(posedge aclk);
        if (arready) arvalid <= 0;
        if (rvalid) begin
          rready <= 0;
          rq = rdata;
          rs = rresp;
          ok = 1;
        end
      end
      if (!ok) begin
        fails = fails + 1;
        final_report;
      end
      @(posedge aclk);
    end
  endtask
  task go(input [7:0] dst, input [15:0] st);
    begin
      wr(`IDX_DST, dst);
      wr(`IDX_CTRL, 32'h1);
      rq = 1;
      for (n = 0; n < 5000 && rq[0]; n = n + 1) rd(`IDX_STAT);
      chk("status", st, rq[15:0]);
    end
  endtask
  task put(input [7:0] c);
    begin
      ex.push_back(c);
      s = s + c;
    end
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`IDX_SNDS); chk("sends", 32'h3, rq);
    rd(`IDX_RTMO); chk("reply tmo", 32'ha, rq);
    rd(`IDX_SPR); chk("spare", 32'h0, rq);
    rd(10'h3ff); chk("bad rd", 32'h2, {30'h0, rs});
    wr(10'h3ff, 32'h0); chk("bad wr", 32'h2, {30'h0, rs});
    wr(`IDX_SRC, 8'h20); wr(`IDX_FNC, 8'h5a); wr(`IDX_SIZ, 8'h01);
    rd(`IDX_FNC); chk("fnc", 32'h5a, rq);
    wr(`IDX_PTR, 32'h0); wr(`IDX_DATA, 8'h41); wr(`IDX_DATA, 8'h03);
    go(8'h31, 16'hb302);
    drv <= 1;
    repeat (3) @(posedge aclk);
    go(8'h20, 16'hb102);
    chk("quiet", 0, p.got.size());
    p.naks = 1;
    go(8'h31, 16'h0000);
    // busy drops while EOT is still on the line
    repeat (300) @(posedge aclk);
    put(8'h31); put(8'h31); put(8'h20); put(8'h05);
    for (n = 0; n < 2; n = n + 1) begin
      s = 0;
      put(8'h01); put(8'h00); put(8'h31); put(8'h20); put(8'h5a); put(8'h01); put(-s);
    end
    s = 0;
    put(8'h02); put(8'h41); put(8'h03); put(8'h03); put(-s); put(8'h04);
    chk("length", ex.size(), p.got.size());
    for (n = 0; n < ex.size(); n = n + 1)
      chk("byte", ex[n], p.got[n]);
    final_report;
  end
endmodule // block_link_controller_bench
